//--- logic/wrf_core.sv
`timescale 1ns/10ps
`include "wrf_regs.svh"
// Function
// - Sixteen 16-bit registers, any usable as operand
// - Register 0 is the default working register
// - Divide quotient to register 0, remainder 1
// - Word file multiply: high word 3, low 2
// - Byte file multiply writes register 2 only
// - 17x17 multiply into accumulator or even pair
// - Prefetch MAC operands only from registers 4-7
// - Prefetch pointers 8,9 X; 10,11 Y
// - Register 12 is the prefetch offset index
// - Register 13 takes accumulator write back
// - Plain accumulator instructions use any register
// - Mixed sign mode: 4,6 unsigned; 5,7 signed
// - Register 14 is the frame pointer
// - Register 15 is the stack pointer
// - Registers 14, 15 stay usable as generic
// - Byte or word moves via default register
// - Word file moves use any register
module wrf_core
	import wrf_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Generic write port
	input wire logic wr_en,
	input wire logic wr_byte,
	input wire wrf_idx_t wr_addr,
	input wire wrf_word_t wr_data,
	// Generic read ports
	input wire wrf_idx_t rd_a_addr,
	input wire wrf_idx_t rd_b_addr,
	output wrf_word_t rd_a_data,
	output wrf_word_t rd_b_data,
	// Default working register moves
	input wire logic dflt_wr_en,
	input wire logic dflt_byte,
	input wire wrf_word_t dflt_wr_data,
	output wrf_word_t dflt_rd_data,
	// Divide result
	input wire logic div_en,
	input wire wrf_word_t div_quot,
	input wire wrf_word_t div_rem,
	// Legacy file multiply
	input wire logic fmul_en,
	input wire logic fmul_byte,
	input wire wrf_word_t fmul_file_data,
	// Multiplier
	input wire logic mul_en,
	input wire logic mul_mac,
	input wire logic mul_to_acc,
	input wire logic [2:0] mul_dst_pair,
	input wire wrf_idx_t mul_a_sel,
	input wire wrf_idx_t mul_b_sel,
	input wire logic mul_a_signed,
	input wire logic mul_b_signed,
	input wire logic [1:0] multiply_sign_mode_field,
	output wrf_wide_t acc_prod,
	output logic acc_prod_vld,
	// Prefetch pointers and write back
	input wire logic pf_x_sel,
	input wire logic pf_y_sel,
	input wire logic pf_x_ofs,
	input wire logic pf_y_ofs,
	input wire logic pf_x_wr,
	input wire wrf_word_t pf_x_val,
	input wire logic pf_y_wr,
	input wire wrf_word_t pf_y_val,
	input wire logic wb_en,
	input wire wrf_word_t wb_data,
	output wrf_word_t pf_x_addr,
	output wrf_word_t pf_y_addr,
	// Frame and stack
	input wire logic frame_link_instruction,
	input wire wrf_word_t lnk_size,
	input wire logic frame_unlink_instruction,
	input wire wrf_word_t frame_unlink_instruction_fp,
	input wire logic stk_push,
	input wire logic stk_pop,
	output wrf_word_t frame_ptr,
	output wrf_word_t stack_ptr
);

	wrf_word_t default_working_register [16];
	wrf_word_t next_w [16];

	// Legacy file multiply products
	wire [15:0] fmul_prod_b;
	wire wrf_prod_t fmul_prod_w;
	assign fmul_prod_b = 16'(fmul_file_data[7:0] * default_working_register[`WRF_IDX_DFLT][7:0]);
	assign fmul_prod_w = 32'(fmul_file_data * default_working_register[`WRF_IDX_DFLT]);

	// Multiplier operand selection
	wire wrf_idx_t mul_a_idx;
	wire wrf_idx_t mul_b_idx;
	wire mixed_mode;
	wire a_sgn;
	wire b_sgn;
	wire [16:0] op_a;
	wire [16:0] op_b;
	wire wrf_wide_t mul_prod;
	wire mul_pair_we;
	assign mul_a_idx = mul_mac ? {`WRF_MAC_OP_HI, mul_a_sel[1:0]} : mul_a_sel;
	assign mul_b_idx = mul_mac ? {`WRF_MAC_OP_HI, mul_b_sel[1:0]} : mul_b_sel;
	assign mixed_mode = mul_mac && (multiply_sign_mode_field == `WRF_SIGN_MIXED);
	assign a_sgn = mixed_mode ? mul_a_idx[0] : mul_a_signed;
	assign b_sgn = mixed_mode ? mul_b_idx[0] : mul_b_signed;
	assign op_a = {a_sgn & default_working_register[mul_a_idx][15], default_working_register[mul_a_idx]};
	assign op_b = {b_sgn & default_working_register[mul_b_idx][15], default_working_register[mul_b_idx]};
	assign mul_prod = 34'($signed(op_a) * $signed(op_b));
	assign mul_pair_we = mul_en && !mul_to_acc;

	// Prefetch pointer selection
	wire wrf_idx_t pf_x_idx;
	wire wrf_idx_t pf_y_idx;
	wire wrf_word_t pf_x_next;
	wire wrf_word_t pf_y_next;
	assign pf_x_idx = {`WRF_PF_X_HI, pf_x_sel};
	assign pf_y_idx = {`WRF_PF_Y_HI, pf_y_sel};
	assign pf_x_next = default_working_register[pf_x_idx] + (pf_x_ofs ? default_working_register[`WRF_IDX_PF_OFS] : 16'h0000);
	assign pf_y_next = default_working_register[pf_y_idx] + (pf_y_ofs ? default_working_register[`WRF_IDX_PF_OFS] : 16'h0000);

	// Frame and stack pointer updates
	wire wrf_word_t sp_now;
	wire wrf_word_t fp_now;
	wire sp_we;
	wire fp_we;
	wire wrf_word_t sp_d;
	wire wrf_word_t fp_d;
	assign sp_now = default_working_register[`WRF_IDX_SP];
	assign fp_now = default_working_register[`WRF_IDX_FP];
	assign sp_we = frame_link_instruction || frame_unlink_instruction || stk_push || stk_pop;
	assign fp_we = frame_link_instruction || frame_unlink_instruction;
	assign sp_d = frame_link_instruction ? sp_now + `WRF_STK_STEP + lnk_size :
		frame_unlink_instruction ? fp_now - `WRF_STK_STEP :
		stk_push ? sp_now + `WRF_STK_STEP : sp_now - `WRF_STK_STEP;
	assign fp_d = frame_link_instruction ? sp_now + `WRF_STK_STEP : frame_unlink_instruction_fp;

	// Per-register write selection, fixed roles before generic writes
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_reg
			localparam logic [3:0] IDX = 4'(gi);
			wire div_hit;
			wire fmul_hit;
			wire mul_hit;
			wire pf_hit;
			wire sp_hit;
			wire fp_hit;
			wire dflt_hit;
			wire gen_hit;
			wire wrf_word_t fmul_d;
			wire wrf_word_t role_d;
			assign div_hit = div_en && (IDX == `WRF_IDX_QUOT || IDX == `WRF_IDX_REM);
			assign fmul_hit = fmul_en && (IDX == `WRF_IDX_PROD_LO || (IDX == `WRF_IDX_PROD_HI && !fmul_byte));
			assign fmul_d = (IDX == `WRF_IDX_PROD_HI) ? fmul_prod_w[31:16] :
				(fmul_byte ? fmul_prod_b : fmul_prod_w[15:0]);
			assign mul_hit = mul_pair_we && (mul_dst_pair == IDX[3:1]);
			assign pf_hit = (pf_x_wr && IDX == pf_x_idx) || (pf_y_wr && IDX == pf_y_idx) ||
				(wb_en && IDX == `WRF_IDX_WB);
			assign sp_hit = sp_we && IDX == `WRF_IDX_SP;
			assign fp_hit = fp_we && IDX == `WRF_IDX_FP;
			assign dflt_hit = dflt_wr_en && IDX == `WRF_IDX_DFLT;
			assign gen_hit = wr_en && wr_addr == IDX;
			assign role_d = div_hit ? ((IDX == `WRF_IDX_QUOT) ? div_quot : div_rem) :
				fmul_hit ? fmul_d :
				mul_hit ? (IDX[0] ? mul_prod[31:16] : mul_prod[15:0]) :
				(pf_x_wr && IDX == pf_x_idx) ? pf_x_val :
				(pf_y_wr && IDX == pf_y_idx) ? pf_y_val :
				pf_hit ? wb_data :
				sp_hit ? sp_d :
				fp_d;
			assign next_w[gi] = (div_hit || fmul_hit || mul_hit || pf_hit || sp_hit || fp_hit) ? role_d :
				dflt_hit ? (dflt_byte ? {default_working_register[gi][15:8], dflt_wr_data[7:0]} : dflt_wr_data) :
				gen_hit ? (wr_byte ? {default_working_register[gi][15:8], wr_data[7:0]} : wr_data) :
				default_working_register[gi];

			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					default_working_register[gi] <= (IDX == `WRF_IDX_SP) ? `WRF_SP_RESET : 16'h0000;
				end else begin
					default_working_register[gi] <= next_w[gi];
				end
			end
		end
	endgenerate

	// Registered views
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rd_a_data <= 16'h0000;
			rd_b_data <= 16'h0000;
			dflt_rd_data <= 16'h0000;
			pf_x_addr <= 16'h0000;
			pf_y_addr <= 16'h0000;
			frame_ptr <= 16'h0000;
			stack_ptr <= `WRF_SP_RESET;
		end else begin
			rd_a_data <= default_working_register[rd_a_addr];
			rd_b_data <= default_working_register[rd_b_addr];
			dflt_rd_data <= default_working_register[`WRF_IDX_DFLT];
			pf_x_addr <= pf_x_next;
			pf_y_addr <= pf_y_next;
			frame_ptr <= fp_now;
			stack_ptr <= sp_now;
		end
	end

	// Accumulator product
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			acc_prod <= 34'h0;
			acc_prod_vld <= 1'b0;
		end else begin
			acc_prod <= mul_prod;
			acc_prod_vld <= mul_en && mul_to_acc;
		end
	end

	// Checks
	sequence s_dflt_word;
		dflt_wr_en && !dflt_byte && !div_en && !mul_pair_we && !(wr_en && wr_addr == `WRF_IDX_DFLT);
	endsequence
	sequence s_w0_quiet;
		!div_en && !dflt_wr_en && !mul_pair_we && !wr_en;
	endsequence

	property p_div;
		@(posedge sys_clk) disable iff (rst)
		div_en |=> default_working_register[`WRF_IDX_QUOT] == $past(div_quot) && default_working_register[`WRF_IDX_REM] == $past(div_rem);
	endproperty
	a_div: assert property (p_div) else $error("divide result misplaced");

	property p_fmul_word;
		@(posedge sys_clk) disable iff (rst)
		fmul_en && !fmul_byte && !div_en |=>
			{default_working_register[`WRF_IDX_PROD_HI], default_working_register[`WRF_IDX_PROD_LO]} == 32'($past(fmul_file_data) * $past(default_working_register[0]));
	endproperty
	a_fmul_word: assert property (p_fmul_word) else $error("word file product wrong");

	property p_fmul_byte;
		@(posedge sys_clk) disable iff (rst)
		fmul_en && fmul_byte && !div_en && !mul_pair_we && !wr_en |=>
			$stable(default_working_register[`WRF_IDX_PROD_HI]) && default_working_register[`WRF_IDX_PROD_LO] == 16'($past(fmul_file_data[7:0]) * $past(default_working_register[0][7:0]));
	endproperty
	a_fmul_byte: assert property (p_fmul_byte) else $error("byte file product wrong");

	property p_dflt_move;
		@(posedge sys_clk) disable iff (rst)
		s_dflt_word ##1 s_w0_quiet |=> dflt_rd_data == $past(dflt_wr_data, 2);
	endproperty
	a_dflt_move: assert property (p_dflt_move) else $error("default register move lost");

	property p_byte_keep;
		@(posedge sys_clk) disable iff (rst)
		wr_en && wr_byte && !dflt_wr_en && !div_en && !fmul_en && !mul_pair_we && !pf_x_wr && !pf_y_wr && !wb_en && !sp_we
		|=> default_working_register[$past(wr_addr)] == {$past(default_working_register[wr_addr][15:8]), $past(wr_data[7:0])};
	endproperty
	a_byte_keep: assert property (p_byte_keep) else $error("byte write touched upper byte");

	property p_mac_ops;
		@(posedge sys_clk) disable iff (rst)
		mul_en && mul_mac |-> op_a[15:0] == default_working_register[{`WRF_MAC_OP_HI, mul_a_sel[1:0]}]
			&& op_b[15:0] == default_working_register[{`WRF_MAC_OP_HI, mul_b_sel[1:0]}];
	endproperty
	a_mac_ops: assert property (p_mac_ops) else $error("prefetch operand outside 4-7");

	property p_mixed;
		@(posedge sys_clk) disable iff (rst)
		mixed_mode && mul_en |-> op_a[16] == (mul_a_sel[0] & default_working_register[{`WRF_MAC_OP_HI, mul_a_sel[1:0]}][15])
			&& op_b[16] == (mul_b_sel[0] & default_working_register[{`WRF_MAC_OP_HI, mul_b_sel[1:0]}][15]);
	endproperty
	a_mixed: assert property (p_mixed) else $error("mixed sign extension wrong");

	property p_pf_x;
		@(posedge sys_clk) disable iff (rst)
		!pf_x_ofs |=> pf_x_addr == $past(default_working_register[{3'h4, pf_x_sel}]);
	endproperty
	a_pf_x: assert property (p_pf_x) else $error("X prefetch pointer wrong");

	property p_push;
		@(posedge sys_clk) disable iff (rst)
		stk_push && !frame_link_instruction && !frame_unlink_instruction && !div_en && !fmul_en && !mul_pair_we
			&& !pf_x_wr && !pf_y_wr && !wb_en |=> ##1 stack_ptr == $past(default_working_register[15], 2) + 16'h0002;
	endproperty
	a_push: assert property (p_push) else $error("stack pointer not advanced");

	property p_link;
		@(posedge sys_clk) disable iff (rst)
		frame_link_instruction && !mul_pair_we |=> default_working_register[14] == $past(default_working_register[15]) + 16'h0002;
	endproperty
	a_link: assert property (p_link) else $error("frame pointer not linked");

	property p_pf_y;
		@(posedge sys_clk) disable iff (rst)
		!pf_y_ofs |=> pf_y_addr == $past(default_working_register[{`WRF_PF_Y_HI, pf_y_sel}]);
	endproperty
	a_pf_y: assert property (p_pf_y) else $error("Y prefetch pointer wrong");

	property p_pf_ofs;
		@(posedge sys_clk) disable iff (rst)
		pf_x_ofs |=> pf_x_addr == 16'($past(default_working_register[{`WRF_PF_X_HI, pf_x_sel}]) + $past(default_working_register[`WRF_IDX_PF_OFS]));
	endproperty
	a_pf_ofs: assert property (p_pf_ofs) else $error("prefetch offset not applied");

	property p_wb;
		@(posedge sys_clk) disable iff (rst)
		wb_en && !mul_pair_we |=> default_working_register[`WRF_IDX_WB] == $past(wb_data);
	endproperty
	a_wb: assert property (p_wb) else $error("write back register missed");

	property p_unlink;
		@(posedge sys_clk) disable iff (rst)
		frame_unlink_instruction && !frame_link_instruction && !mul_pair_we |=>
			default_working_register[`WRF_IDX_SP] == 16'($past(default_working_register[`WRF_IDX_FP]) - `WRF_STK_STEP) && default_working_register[`WRF_IDX_FP] == $past(frame_unlink_instruction_fp);
	endproperty
	a_unlink: assert property (p_unlink) else $error("frame not unlinked");

	property p_pop;
		@(posedge sys_clk) disable iff (rst)
		stk_pop && !stk_push && !fp_we && !mul_pair_we |=>
			default_working_register[`WRF_IDX_SP] == 16'($past(default_working_register[`WRF_IDX_SP]) - `WRF_STK_STEP);
	endproperty
	a_pop: assert property (p_pop) else $error("stack pointer not retreated");

	property p_acc_vld;
		@(posedge sys_clk) disable iff (rst)
		mul_en && mul_to_acc |=> acc_prod_vld;
	endproperty
	a_acc_vld: assert property (p_acc_vld) else $error("accumulator product not flagged");

	property p_acc_idle;
		@(posedge sys_clk) disable iff (rst)
		!mul_en |=> !acc_prod_vld;
	endproperty
	a_acc_idle: assert property (p_acc_idle) else $error("accumulator flag without multiply");

	property p_rd;
		@(posedge sys_clk) disable iff (rst)
		!rst |=> rd_a_data == $past(default_working_register[rd_a_addr]) && rd_b_data == $past(default_working_register[rd_b_addr]);
	endproperty
	a_rd: assert property (p_rd) else $error("read port shows wrong register");

	property p_dflt_byte;
		@(posedge sys_clk) disable iff (rst)
		dflt_wr_en && dflt_byte && !div_en && !mul_pair_we |=>
			default_working_register[`WRF_IDX_DFLT] == {$past(default_working_register[`WRF_IDX_DFLT][15:8]), $past(dflt_wr_data[7:0])};
	endproperty
	a_dflt_byte: assert property (p_dflt_byte) else $error("default byte move touched upper byte");

	property p_gen_word;
		@(posedge sys_clk) disable iff (rst)
		wr_en && !wr_byte && !dflt_wr_en && !div_en && !fmul_en && !mul_pair_we && !pf_x_wr && !pf_y_wr && !wb_en && !sp_we
		|=> default_working_register[$past(wr_addr)] == $past(wr_data);
	endproperty
	a_gen_word: assert property (p_gen_word) else $error("word write lost");

endmodule : wrf_core

//--- logic/wrf_pkg.sv
package wrf_pkg;
	typedef logic [15:0] wrf_word_t;
	typedef logic [3:0] wrf_idx_t;
	typedef logic [31:0] wrf_prod_t;
	typedef logic [33:0] wrf_wide_t;
endpackage : wrf_pkg

//--- logic/wrf_regs.svh
`ifndef WRF_REGS_SVH
`define WRF_REGS_SVH

// Working register indices with fixed roles
`define WRF_IDX_DFLT 4'h0
`define WRF_IDX_QUOT 4'h0
`define WRF_IDX_REM 4'h1
`define WRF_IDX_PROD_LO 4'h2
`define WRF_IDX_PROD_HI 4'h3
`define WRF_MAC_OP_HI 2'h1
`define WRF_PF_X_HI 3'h4
`define WRF_PF_Y_HI 3'h5
`define WRF_IDX_PF_OFS 4'hc
`define WRF_IDX_WB 4'hd
`define WRF_IDX_FP 4'he
`define WRF_IDX_SP 4'hf

// Field values and reset values
`define WRF_SIGN_MIXED 2'h2
`define WRF_SP_RESET 16'h0800
`define WRF_STK_STEP 16'h0002

`endif

//--- verification/working_register_file_roles_tb_top.sv
`timescale 1ns/10ps
module working_register_file_roles_tb_top
	import wrf_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic wr_byte, dflt_byte, fmul_byte, mul_mac, mul_to_acc, mul_a_signed, mul_b_signed;
	logic pf_x_sel, pf_y_sel, pf_x_ofs, pf_y_ofs;
	logic [2:0] mul_dst_pair;
	logic [1:0] multiply_sign_mode_field;
	wrf_idx_t wr_addr, rd_a_addr, rd_b_addr, mul_a_sel, mul_b_sel;
	wrf_word_t wr_data, dflt_wr_data, div_quot, div_rem, fmul_file_data, pf_x_val, pf_y_val, wb_data, lnk_size, frame_unlink_instruction_fp;
	wire logic wr_en, dflt_wr_en, div_en, fmul_en, mul_en, pf_x_wr, pf_y_wr, wb_en;
	wire logic frame_link_instruction, frame_unlink_instruction, stk_push, stk_pop, acc_prod_vld;
	wire wrf_word_t rd_a_data, rd_b_data, dflt_rd_data, pf_x_addr, pf_y_addr, frame_ptr, stack_ptr;
	wire wrf_wide_t acc_prod;
	int err_total = 0;
	int cmp_count = 0;
	initial {wr_byte, dflt_byte, fmul_byte, mul_mac, mul_to_acc, mul_a_signed, mul_b_signed, pf_x_sel, pf_y_sel,
		pf_x_ofs, pf_y_ofs, mul_dst_pair, multiply_sign_mode_field, wr_addr, rd_a_addr, rd_b_addr, mul_a_sel,
		mul_b_sel, wr_data, dflt_wr_data, div_quot, div_rem, fmul_file_data, pf_x_val, pf_y_val, wb_data,
		lnk_size, frame_unlink_instruction_fp} = '0;
	always #2.5 sys_clk = ~sys_clk;
	wrf_core u_wrf_core (
		.sys_clk(sys_clk), .rst(rst),
		.wr_en(wr_en), .wr_byte(wr_byte), .wr_addr(wr_addr), .wr_data(wr_data),
		.rd_a_addr(rd_a_addr), .rd_b_addr(rd_b_addr), .rd_a_data(rd_a_data), .rd_b_data(rd_b_data),
		.dflt_wr_en(dflt_wr_en), .dflt_byte(dflt_byte), .dflt_wr_data(dflt_wr_data), .dflt_rd_data(dflt_rd_data),
		.div_en(div_en), .div_quot(div_quot), .div_rem(div_rem),
		.fmul_en(fmul_en), .fmul_byte(fmul_byte), .fmul_file_data(fmul_file_data),
		.mul_en(mul_en), .mul_mac(mul_mac), .mul_to_acc(mul_to_acc), .mul_dst_pair(mul_dst_pair),
		.mul_a_sel(mul_a_sel), .mul_b_sel(mul_b_sel), .mul_a_signed(mul_a_signed), .mul_b_signed(mul_b_signed),
		.multiply_sign_mode_field(multiply_sign_mode_field), .acc_prod(acc_prod), .acc_prod_vld(acc_prod_vld),
		.pf_x_sel(pf_x_sel), .pf_y_sel(pf_y_sel), .pf_x_ofs(pf_x_ofs), .pf_y_ofs(pf_y_ofs),
		.pf_x_wr(pf_x_wr), .pf_x_val(pf_x_val), .pf_y_wr(pf_y_wr), .pf_y_val(pf_y_val),
		.wb_en(wb_en), .wb_data(wb_data), .pf_x_addr(pf_x_addr), .pf_y_addr(pf_y_addr),
		.frame_link_instruction(frame_link_instruction), .lnk_size(lnk_size),
		.frame_unlink_instruction(frame_unlink_instruction), .frame_unlink_instruction_fp(frame_unlink_instruction_fp),
		.stk_push(stk_push), .stk_pop(stk_pop), .frame_ptr(frame_ptr), .stack_ptr(stack_ptr)
	);
	wrf_em u_wrf_em (
		.sys_clk(sys_clk), .wr_en(wr_en), .dflt_wr_en(dflt_wr_en), .div_en(div_en), .fmul_en(fmul_en),
		.mul_en(mul_en), .pf_x_wr(pf_x_wr), .pf_y_wr(pf_y_wr), .wb_en(wb_en),
		.frame_link_instruction(frame_link_instruction), .frame_unlink_instruction(frame_unlink_instruction),
		.stk_push(stk_push), .stk_pop(stk_pop)
	);
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string n, input logic [33:0] e, input logic [33:0] s);
		cmp_count++;
		if (s !== e) begin
			$display("MISMATCH %s expected %h seen %h", n, e, s);
			err_total++;
		end
	endtask : chk
	task automatic tick;
		@(negedge sys_clk);
	endtask : tick
	task automatic wr(input wrf_idx_t a, input wrf_word_t d);
		wr_addr = a;
		wr_data = d;
		u_wrf_em.fire(12'h800);
	endtask : wr
	task automatic rd(input wrf_idx_t a, input wrf_word_t e);
		rd_a_addr = a;
		tick();
		chk("rd_a_data", e, rd_a_data);
	endtask : rd
	task automatic t_generic;
		chk("stack_ptr", 16'h0800, stack_ptr);
		rd(4'hf, 16'h0800);
		for (int i = 0; i < 16; i++) wr(wrf_idx_t'(i), wrf_word_t'(i * 16'h1111));
		for (int i = 0; i < 16; i++) rd(wrf_idx_t'(i), wrf_word_t'(i * 16'h1111));
		rd_b_addr = 4'he;
		rd(4'h1, 16'h1111);
		chk("rd_b_data", 16'heeee, rd_b_data);
		$display("test generic done");
	endtask : t_generic
	task automatic t_byte;
		wr_byte = 1'b1;
		wr(4'h6, 16'h00ab);
		wr_byte = 1'b0;
		rd(4'h6, 16'h66ab);
		dflt_byte = 1'b1;
		dflt_wr_data = 16'h1234;
		u_wrf_em.fire(12'h400);
		tick();
		chk("dflt_rd_data", 16'h0034, dflt_rd_data);
		dflt_byte = 1'b0;
		dflt_wr_data = 16'h7705;
		u_wrf_em.fire(12'h400);
		tick();
		chk("dflt_rd_data", 16'h7705, dflt_rd_data);
		$display("test byte done");
	endtask : t_byte
	task automatic t_fmul_div;
		fmul_file_data = 16'h1255;
		u_wrf_em.fire(12'h100);
		rd(4'h3, 16'h0885);
		rd(4'h2, 16'hdea9);
		fmul_byte = 1'b1;
		u_wrf_em.fire(12'h100);
		rd(4'h2, 16'h01a9);
		rd(4'h3, 16'h0885);
		div_quot = 16'h0012;
		div_rem = 16'h0003;
		u_wrf_em.fire(12'h200);
		rd(4'h0, 16'h0012);
		rd(4'h1, 16'h0003);
		$display("test fmul div done");
	endtask : t_fmul_div
	task automatic t_mul;
		mul_a_sel = 4'h8;
		mul_b_sel = 4'h9;
		mul_dst_pair = 3'h3;
		u_wrf_em.fire(12'h080);
		rd(4'h6, 16'he148);
		rd(4'h7, 16'h51ea);
		wr(4'h4, 16'hffff);
		wr(4'h5, 16'hffff);
		mul_mac = 1'b1;
		mul_to_acc = 1'b1;
		mul_a_signed = 1'b1;
		multiply_sign_mode_field = 2'h2;
		mul_a_sel = 4'hc;
		mul_b_sel = 4'hd;
		u_wrf_em.fire(12'h080);
		chk("acc_prod_vld", 1'b1, acc_prod_vld);
		chk("acc_prod", 34'h3ffff0001, acc_prod);
		tick();
		chk("acc_prod_vld", 1'b0, acc_prod_vld);
		mul_mac = 1'b0;
		mul_b_signed = 1'b1;
		mul_a_sel = 4'h4;
		mul_b_sel = 4'h5;
		u_wrf_em.fire(12'h080);
		chk("acc_prod", 34'h000000001, acc_prod);
		rd(4'h6, 16'he148);
		$display("test mul done");
	endtask : t_mul
	task automatic t_pf;
		pf_x_sel = 1'b1;
		pf_x_ofs = 1'b1;
		pf_y_sel = 1'b0;
		pf_y_ofs = 1'b1;
		tick();
		tick();
		chk("pf_x_addr", 16'h6665, pf_x_addr);
		chk("pf_y_addr", 16'h7776, pf_y_addr);
		pf_x_val = 16'h0100;
		u_wrf_em.fire(12'h040);
		tick();
		chk("pf_x_addr", 16'hcdcc, pf_x_addr);
		wb_data = 16'hbeef;
		u_wrf_em.fire(12'h010);
		rd(4'hd, 16'hbeef);
		pf_y_sel = 1'b1;
		pf_y_val = 16'h0200;
		u_wrf_em.fire(12'h020);
		tick();
		chk("pf_y_addr", 16'hcecc, pf_y_addr);
		pf_y_ofs = 1'b0;
		tick();
		chk("pf_y_addr", 16'h0200, pf_y_addr);
		$display("test prefetch done");
	endtask : t_pf
	task automatic t_frame;
		wr(4'hf, 16'h0900);
		u_wrf_em.fire(12'h002);
		tick();
		chk("stack_ptr", 16'h0902, stack_ptr);
		lnk_size = 16'h0004;
		u_wrf_em.fire(12'h008);
		tick();
		chk("frame_ptr", 16'h0904, frame_ptr);
		chk("stack_ptr", 16'h0908, stack_ptr);
		frame_unlink_instruction_fp = 16'h0040;
		u_wrf_em.fire(12'h004);
		tick();
		chk("frame_ptr", 16'h0040, frame_ptr);
		chk("stack_ptr", 16'h0902, stack_ptr);
		u_wrf_em.fire(12'h001);
		tick();
		chk("stack_ptr", 16'h0900, stack_ptr);
		$display("test frame done");
	endtask : t_frame
	task automatic t_reset;
		rst = 1'b1;
		tick();
		chk("stack_ptr", 16'h0800, stack_ptr);
		chk("frame_ptr", 16'h0000, frame_ptr);
		chk("acc_prod_vld", 1'b0, acc_prod_vld);
		rst = 1'b0;
		rd(4'hd, 16'h0000);
		rd(4'hf, 16'h0800);
		$display("test reset done");
	endtask : t_reset
	initial begin
		#20000;
		err_total++;
		tally_and_finish();
	end
	initial begin
		repeat (16) @(negedge sys_clk);
		rst = 1'b0;
		t_generic();
		t_byte();
		t_fmul_div();
		t_mul();
		t_pf();
		t_frame();
		t_reset();
		tally_and_finish();
	end
endmodule : working_register_file_roles_tb_top

//--- verification/wrf_em.sv
`timescale 1ns/10ps
module wrf_em
	import wrf_pkg::*;
(
	// Clock
	input wire logic sys_clk,
	// Write strobes
	output wire logic wr_en,
	output wire logic dflt_wr_en,
	output wire logic div_en,
	output wire logic fmul_en,
	output wire logic mul_en,
	// Prefetch strobes
	output wire logic pf_x_wr,
	output wire logic pf_y_wr,
	output wire logic wb_en,
	// Frame and stack strobes
	output wire logic frame_link_instruction,
	output wire logic frame_unlink_instruction,
	output wire logic stk_push,
	output wire logic stk_pop
);
	logic [11:0] st = 12'h000;
	assign {wr_en, dflt_wr_en, div_en, fmul_en, mul_en, pf_x_wr, pf_y_wr, wb_en,
		frame_link_instruction, frame_unlink_instruction, stk_push, stk_pop} = st;
	// One request, held across one rising edge
	task automatic fire(input logic [11:0] s);
		@(negedge sys_clk);
		st = s;
		@(negedge sys_clk);
		st = 12'h000;
	endtask : fire
endmodule : wrf_em
